// File: logic/dhsfs_map.svh
// timing constants for the dual hot-swap fault sequencer
`ifndef DHSFS_MAP_SVH
`define DHSFS_MAP_SVH
// clock period in picoseconds (250 MHz)
`define DHSFS_CLK_PS 4000
// time base tick: 10 us
`define DHSFS_TICK_NS 10000
`define DHSFS_TICK_CYC (`DHSFS_TICK_NS * 1000 / `DHSFS_CLK_PS)
// delays in microseconds, counted in 10 us ticks
`define DHSFS_LOCKOUT_US 37500
`define DHSFS_LOCKOUT_TICKS (`DHSFS_LOCKOUT_US * 1000 / `DHSFS_TICK_NS)
`define DHSFS_START_DEF_US 9000
`define DHSFS_START_DEF_TICKS (`DHSFS_START_DEF_US * 1000 / `DHSFS_TICK_NS)
`define DHSFS_START_MAX_US 50000
`define DHSFS_START_MAX_TICKS (`DHSFS_START_MAX_US * 1000 / `DHSFS_TICK_NS)
`define DHSFS_PG_US 750
`define DHSFS_PG_TICKS (`DHSFS_PG_US * 1000 / `DHSFS_TICK_NS)
`define DHSFS_CLEAR_US 100
`define DHSFS_CLEAR_TICKS (`DHSFS_CLEAR_US * 1000 / `DHSFS_TICK_NS)
`define DHSFS_GLITCH_US 20
`define DHSFS_GLITCH_TICKS (`DHSFS_GLITCH_US * 1000 / `DHSFS_TICK_NS)
// autoretry wait is this many startup periods
`define DHSFS_RETRY_MULT 64
`define DHSFS_CNT_W 20
`define DHSFS_TICK_W 12
`define DHSFS_MULT_W 7
`endif

// File: logic/dhsfs_pkg.sv
// types for the dual hot-swap fault sequencer
package dhsfs_pkg;
  typedef enum logic [2:0] {
    ST_LOCKOUT, ST_WAIT_ON, ST_STARTUP, ST_RUN, ST_LATCHED, ST_RETRY
  } dhsfs_state_t;

  // per-channel comparator decisions
  typedef struct packed {
    logic fast_trip;
    logic slow_trip;
    logic window_low;
    logic window_high;
  } dhsfs_sense_t;

  // per-channel commands toward the gate drivers and status pin
  typedef struct packed {
    logic gate_on;
    logic gate_discharge;
    logic startup_limit;
    logic pg_out;
    logic pg_oe;
  } dhsfs_drive_t;
endpackage

// File: logic/dhsfs_sequencer.sv
// control sequencer for a dual-channel hot-swap breaker
// What this block does
// - startup begins after lockout release delay, both on-requests, no latch or retry wait
// - startup period is 9ms by default, adjustable up to 50ms
// - slow overcurrent trip is ignored during startup
// - fast trip during startup only limits current, no fault and no turn-off
// - power-good released 0.75ms after startup when no fault
// - after startup a slow trip faults, drops both power-goods, discharges both gates
// - after startup a fast trip faults immediately with the same response
// - both supplies below lockout restart the lockout delay and then startup
// - latched fault cleared by on-request low or supply cycle held 100us
// - autoretry restarts after 64 startup periods
// - on-request drop does not clear an autoretry wait
// - supply cycle during autoretry wait starts startup at once
// - window monitors act only after startup, outside window is a fault
// - protection variant: voltage fault discharges both gates, drops both power-goods
// - protection with autoretry retries each wait until fault is gone
// - protection with latching stays off until fault gone and latch cleared
// - monitoring variant drops only the faulty power-good, gates stay on
// - monitor excursions shorter than 20us are ignored
// - power-good low while its on-request is low
// - power-good low during startup, channel off, any overcurrent or protection fault, or a monitor fault on its own channel
`timescale 1ns/10ps
`include "dhsfs_map.svh"
// tick length is a parameter so that a bench can shrink every delay at once
module dhsfs_sequencer #(
  parameter int TICK_CYC = `DHSFS_TICK_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic supply1_ok,
  input wire logic supply2_ok,
  input wire logic on_request1,
  input wire logic on_request2,
  input wire dhsfs_pkg::dhsfs_sense_t sense1,
  input wire dhsfs_pkg::dhsfs_sense_t sense2,
  input wire logic startup_time_set_float,
  input wire logic [`DHSFS_CNT_W-1:0] startup_time_set_ticks,
  input wire logic cfg_autoretry,
  input wire logic cfg_monitor_only,
  output dhsfs_pkg::dhsfs_drive_t first_channel_drive,
  output dhsfs_pkg::dhsfs_drive_t second_channel_drive,
  output logic sequencer_fault,
  output logic startup_active
);
  import dhsfs_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  assign raw_in = {supply1_ok, supply2_ok, on_request1, on_request2,
                   sense1, sense2};
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end
  wire logic sup1 = sync2_q[11];
  wire logic sup2 = sync2_q[10];
  wire logic on1 = sync2_q[9];
  wire logic on2 = sync2_q[8];
  dhsfs_sense_t s1;
  dhsfs_sense_t s2;
  assign s1 = sync2_q[7:4];
  assign s2 = sync2_q[3:0];

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic [`DHSFS_TICK_W-1:0] div_q;
  logic tick_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == `DHSFS_TICK_W'(TICK_CYC - 1));
      div_q <= (div_q == `DHSFS_TICK_W'(TICK_CYC - 1)) ? '0 : div_q + 1'b1;
    end
  end

  // static configuration captured once after reset release
  logic cfg_taken_q;
  logic autoretry_q;
  logic monitor_q;
  logic [`DHSFS_CNT_W-1:0] start_ticks_q;
  wire logic [`DHSFS_CNT_W-1:0] ext_ticks =
    (startup_time_set_ticks > `DHSFS_CNT_W'(`DHSFS_START_MAX_TICKS)) ?
    `DHSFS_CNT_W'(`DHSFS_START_MAX_TICKS) : startup_time_set_ticks;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_taken_q <= 1'b0;
      autoretry_q <= 1'b0;
      monitor_q <= 1'b0;
      start_ticks_q <= `DHSFS_CNT_W'(`DHSFS_START_DEF_TICKS);
    end else if (!cfg_taken_q) begin
      cfg_taken_q <= 1'b1;
      autoretry_q <= cfg_autoretry;
      monitor_q <= cfg_monitor_only;
      start_ticks_q <= startup_time_set_float ? `DHSFS_CNT_W'(`DHSFS_START_DEF_TICKS) :
                       ((ext_ticks == '0) ? `DHSFS_CNT_W'(1) : ext_ticks);
    end
  end

  // ----------------------------------------------------------------
  // supply and on-request qualification
  // ----------------------------------------------------------------
  wire logic any_sup = sup1 | sup2;
  wire logic both_on = on1 & on2;
  // state is declared here because the clear qualifiers and window filters read it
  dhsfs_state_t state_q;
  dhsfs_state_t state_d;
  // clear qualifiers: a low on-request or a supply dropout held for the clear time
  logic [`DHSFS_TICK_W-1:0] onlow_cnt_q;
  logic [`DHSFS_TICK_W-1:0] suplow_cnt_q;
  logic on_cleared_q;
  logic sup_cycled_q;
  wire logic sup_any_low = !sup1 | !sup2;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      onlow_cnt_q <= '0;
      suplow_cnt_q <= '0;
      on_cleared_q <= 1'b0;
      sup_cycled_q <= 1'b0;
    end else begin
      if (both_on) onlow_cnt_q <= '0;
      else if (tick_q && !on_cleared_q) onlow_cnt_q <= onlow_cnt_q + 1'b1;
      if (!sup_any_low) suplow_cnt_q <= '0;
      else if (tick_q && !sup_cycled_q) suplow_cnt_q <= suplow_cnt_q + 1'b1;
      if (onlow_cnt_q >= `DHSFS_TICK_W'(`DHSFS_CLEAR_TICKS)) on_cleared_q <= 1'b1;
      else if (state_q != ST_LATCHED) on_cleared_q <= 1'b0;
      if (suplow_cnt_q >= `DHSFS_TICK_W'(`DHSFS_CLEAR_TICKS)) sup_cycled_q <= 1'b1;
      else if (state_q != ST_LATCHED && state_q != ST_RETRY) sup_cycled_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // window monitors with glitch filter
  // ----------------------------------------------------------------
  logic [`DHSFS_TICK_W-1:0] win_cnt_q [2];
  logic [1:0] vfault_q;
  wire logic [1:0] win_out = {s1.window_low | s1.window_high,
                              s2.window_low | s2.window_high};
  for (genvar i = 0; i < 2; i++) begin : g_win
    always_ff @(posedge clk) begin
      if (!nrst || state_q != ST_RUN || !win_out[i]) begin
        win_cnt_q[i] <= '0;
        vfault_q[i] <= 1'b0;
      end else if (tick_q && !vfault_q[i]) begin
        win_cnt_q[i] <= win_cnt_q[i] + 1'b1;
        if (win_cnt_q[i] >= `DHSFS_TICK_W'(`DHSFS_GLITCH_TICKS)) vfault_q[i] <= 1'b1;
      end
    end
  end
  wire logic any_vfault = |vfault_q;
  // raw window state outside run, so a latched protection fault only clears once healthy
  wire logic win_bad = |win_out;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic [`DHSFS_CNT_W-1:0] cnt_q;
  logic [`DHSFS_MULT_W-1:0] mult_q;
  logic pg_ok_q;
  logic oc_fault_q;
  logic v_latched_q;
  wire logic oc_trip = s1.slow_trip | s2.slow_trip | s1.fast_trip | s2.fast_trip;
  wire logic prot_fault = any_vfault && !monitor_q;
  wire logic run_fault = oc_trip | prot_fault;
  // cnt_q holds finished ticks, so the last tick of an N-tick period sees N-1
  wire logic lockout_done = cnt_q >= `DHSFS_CNT_W'(`DHSFS_LOCKOUT_TICKS - 1);
  wire logic start_done = cnt_q >= start_ticks_q - `DHSFS_CNT_W'(1);
  wire logic retry_done = start_done && (mult_q == `DHSFS_MULT_W'(`DHSFS_RETRY_MULT - 1));
  wire logic latch_clear = (on_cleared_q && both_on) || (sup_cycled_q && !sup_any_low);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_LOCKOUT: if (tick_q && lockout_done && any_sup) state_d = ST_WAIT_ON;
      ST_WAIT_ON: if (both_on) state_d = ST_STARTUP;
      ST_STARTUP: if (!both_on) state_d = ST_WAIT_ON;
        else if (tick_q && start_done) state_d = ST_RUN;
      ST_RUN: if (run_fault) state_d = autoretry_q ? ST_RETRY : ST_LATCHED;
        else if (!both_on) state_d = ST_WAIT_ON;
      ST_LATCHED: if (latch_clear && !(prot_fault || (!monitor_q && win_bad && v_latched_q)))
        state_d = ST_LOCKOUT;
      ST_RETRY: if (sup_cycled_q && !sup_any_low && both_on) state_d = ST_STARTUP;
        else if (tick_q && retry_done) state_d = ST_WAIT_ON;
    endcase
    if (!any_sup) state_d = ST_LOCKOUT;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= ST_LOCKOUT;
      cnt_q <= '0;
      mult_q <= '0;
    end else begin
      state_q <= state_d;
      // lockout release delay only runs while a supply stays up
      if (state_d != state_q || !any_sup) begin
        cnt_q <= '0;
        mult_q <= '0;
      end else if (tick_q) begin
        if (state_q == ST_RETRY && start_done) begin
          cnt_q <= '0;
          mult_q <= mult_q + 1'b1;
        end else if (!(&cnt_q)) cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // fault memory and power-good release delay
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pg_ok_q <= 1'b0;
      oc_fault_q <= 1'b0;
      v_latched_q <= 1'b0;
    end else begin
      pg_ok_q <= (state_q == ST_RUN) && (pg_ok_q ||
                 (tick_q && cnt_q >= `DHSFS_CNT_W'(`DHSFS_PG_TICKS - 1)));
      if (state_q == ST_RUN && run_fault) begin
        oc_fault_q <= 1'b1;
        v_latched_q <= prot_fault;
      end else if (state_q == ST_STARTUP || state_q == ST_LOCKOUT) begin
        oc_fault_q <= 1'b0;
        v_latched_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire logic running = state_q == ST_RUN && !run_fault;
  wire logic gates_up = running || state_q == ST_STARTUP;
  wire logic [1:0] ch_on = {on1, on2};
  // monitoring variant: only the faulty channel drops its power-good
  wire logic [1:0] pg_good = {2{running && pg_ok_q}} & ch_on &
                             ~(vfault_q & {2{monitor_q}});
  dhsfs_drive_t drv_d [2];
  dhsfs_drive_t drv_q [2];
  for (genvar i = 0; i < 2; i++) begin : g_drv
    assign drv_d[i] = '{gate_on: gates_up,
                        gate_discharge: !gates_up,
                        startup_limit: state_q == ST_STARTUP,
                        pg_out: 1'b0,
                        pg_oe: !pg_good[1-i]};
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      drv_q[0] <= '{gate_on: 1'b0, gate_discharge: 1'b1, startup_limit: 1'b0,
                    pg_out: 1'b0, pg_oe: 1'b1};
      drv_q[1] <= '{gate_on: 1'b0, gate_discharge: 1'b1, startup_limit: 1'b0,
                    pg_out: 1'b0, pg_oe: 1'b1};
      sequencer_fault <= 1'b0;
      startup_active <= 1'b0;
    end else begin
      drv_q[0] <= drv_d[0];
      drv_q[1] <= drv_d[1];
      sequencer_fault <= oc_fault_q || any_vfault;
      startup_active <= state_q == ST_STARTUP;
    end
  end
  assign first_channel_drive = drv_q[0];
  assign second_channel_drive = drv_q[1];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence run_trip_s;
    state_q == ST_RUN && oc_trip;
  endsequence
  sequence gates_dropped_s;
    !first_channel_drive.gate_on && second_channel_drive.gate_discharge;
  endsequence
  fault_gate_off_a: assert property (@(posedge clk) disable iff (!nrst)
    run_trip_s |-> ##2 gates_dropped_s) else $error("trip did not drop gates");
  fault_pg_low_a: assert property (@(posedge clk) disable iff (!nrst)
    run_trip_s |-> ##2 (first_channel_drive.pg_oe && second_channel_drive.pg_oe))
    else $error("trip did not pull power-good low");
  startup_no_fault_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == ST_STARTUP && both_on && any_sup) |=> state_q != ST_LATCHED
    && state_q != ST_RETRY) else $error("fault raised during startup");
  startup_entry_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_q != ST_STARTUP ##1 state_q == ST_STARTUP) |-> $past(both_on))
    else $error("startup without on-requests");
  lockout_restart_a: assert property (@(posedge clk) disable iff (!nrst)
    !any_sup |=> state_q == ST_LOCKOUT) else $error("lockout not restarted");
  pg_startup_low_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == ST_STARTUP |-> ##1 first_channel_drive.pg_oe)
    else $error("power-good released in startup");
  pg_delay_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(pg_ok_q) |-> $past(cnt_q) >= `DHSFS_CNT_W'(`DHSFS_PG_TICKS - 1))
    else $error("power-good released early");
  retry_on_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == ST_RETRY && any_sup && !(sup_cycled_q && !sup_any_low) && !(tick_q
    && retry_done)) |=> state_q == ST_RETRY) else $error("retry wait left early");
  monitor_gates_a: assert property (@(posedge clk) disable iff (!nrst)
    (monitor_q && running && any_sup && both_on && !oc_trip) |=> state_q == ST_RUN)
    else $error("monitoring fault changed gates");

  // further sequencing checks
  sequence prot_trip_s;
    state_q == ST_RUN && prot_fault;
  endsequence
  sequence retry_back_s;
    state_q == ST_RETRY && any_sup && sup_cycled_q && !sup_any_low && both_on;
  endsequence
  slow_trip_masked_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == ST_STARTUP && any_sup && both_on && !(tick_q && start_done))
    |=> state_q == ST_STARTUP) else $error("startup left early");
  startup_limit_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == ST_STARTUP |=> (first_channel_drive.startup_limit
    && second_channel_drive.startup_limit)) else $error("startup limit not set");
  prot_gate_off_a: assert property (@(posedge clk) disable iff (!nrst)
    prot_trip_s |-> ##2 gates_dropped_s) else $error("voltage fault kept gates on");
  retry_cancel_a: assert property (@(posedge clk) disable iff (!nrst)
    retry_back_s |=> state_q == ST_STARTUP) else $error("supply cycle kept retry wait");
  window_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q != ST_RUN |=> vfault_q == 2'h0) else $error("window fault outside run");
  latched_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == ST_LATCHED && any_sup && !latch_clear) |=> state_q == ST_LATCHED)
    else $error("latched fault released");
  lockout_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == ST_LOCKOUT && !(tick_q && lockout_done)) |=> state_q == ST_LOCKOUT)
    else $error("lockout left early");
  pg_on_low_a: assert property (@(posedge clk) disable iff (!nrst)
    !on1 |=> first_channel_drive.pg_oe) else $error("power-good released while off");
  monitor_pg_a: assert property (@(posedge clk) disable iff (!nrst)
    (monitor_q && state_q == ST_RUN && vfault_q[1]) |=> first_channel_drive.pg_oe)
    else $error("faulty channel power-good released");
endmodule

// File: tb/dhsfs_plant.sv
// plant model: backplane supplies, pass transistors, sense and window comparators
`timescale 1ns/10ps
module dhsfs_plant (
  input wire logic clk,
  input wire logic sup1_on,
  input wire logic sup2_on,
  input wire logic [1:0] ovl,
  input wire logic [1:0] shrt,
  input wire logic [1:0] wout,
  input wire dhsfs_pkg::dhsfs_drive_t drv1,
  input wire dhsfs_pkg::dhsfs_drive_t drv2,
  output logic sup1_ok,
  output logic sup2_ok,
  output dhsfs_pkg::dhsfs_sense_t sense1,
  output dhsfs_pkg::dhsfs_sense_t sense2
);
  import dhsfs_pkg::*;
  // ------------------------------------------------------------
  // comparators
  // ------------------------------------------------------------
  // no current flows with the gate off, and a dark output sits below the window,
  // so an overcurrent fault that switches the gates off also removes its own cause
  function automatic dhsfs_sense_t sense_of(logic g, logic o, logic s, logic w);
    return '{fast_trip: g & s, slow_trip: g & (o | s), window_low: ~g, window_high: g & w};
  endfunction
  always_ff @(posedge clk) begin
    sup1_ok <= sup1_on;
    sup2_ok <= sup2_on;
    sense1 <= sense_of(drv1.gate_on, ovl[0], shrt[0], wout[0]);
    sense2 <= sense_of(drv2.gate_on, ovl[1], shrt[1], wout[1]);
  end
endmodule

// File: tb/tb_top.sv
// self-checking bench for the dual hot-swap fault sequencer
`timescale 1ns/10ps
`include "dhsfs_map.svh"
module tb_top;
  import dhsfs_pkg::*;
  localparam int TICK = 4;
  localparam int TIMEOUT = 90000;
  localparam logic [11:0] ALL = 12'hFFF;
  localparam logic [11:0] NOF = 12'h7FF;
  localparam logic [4:0] D_OFF = 5'h09;
  localparam logic [4:0] D_START = 5'h15;
  localparam logic [4:0] D_LOW = 5'h11;
  localparam logic [4:0] D_GOOD = 5'h10;
  logic clk, nrst, sup1, sup2, on1, on2, tfloat, cfg_retry, cfg_mon;
  logic [`DHSFS_CNT_W-1:0] tset;
  logic [1:0] ovl, shrt, wout;
  logic s1_ok, s2_ok, fault, starting;
  dhsfs_sense_t sense1, sense2;
  dhsfs_drive_t drv1, drv2;
  logic [11:0] obs;
  logic [23:0] note_q[$];
  event note_ev;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  assign obs = {fault, starting, drv1, drv2};

  dhsfs_plant u_plant (.clk(clk), .sup1_on(sup1), .sup2_on(sup2), .ovl(ovl), .shrt(shrt),
    .wout(wout), .drv1(drv1), .drv2(drv2), .sup1_ok(s1_ok), .sup2_ok(s2_ok),
    .sense1(sense1), .sense2(sense2));
  dhsfs_sequencer #(.TICK_CYC(TICK)) u_dut (.clk(clk), .nrst(nrst), .supply1_ok(s1_ok),
    .supply2_ok(s2_ok),
    .on_request1(on1), .on_request2(on2), .sense1(sense1), .sense2(sense2),
    .startup_time_set_float(tfloat), .startup_time_set_ticks(tset),
    .cfg_autoretry(cfg_retry), .cfg_monitor_only(cfg_mon), .first_channel_drive(drv1),
    .second_channel_drive(drv2), .sequencer_fault(fault), .startup_active(starting));

  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task automatic check(logic [31:0] seen, logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: seen %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic note(logic [11:0] m, logic f, logic s, logic [4:0] d1, logic [4:0] d2);
    note_q.push_back({m, {f, s, d1, d2} & m});
    ->note_ev;
  endtask

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // counts are long, so every wait is bounded and returns the cycles it took
  task automatic wait_bit(int i, logic v, int lim, output int cnt);
    cnt = 0;
    #1;
    while (obs[i] !== v && cnt < lim) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask

  initial begin
    logic [23:0] nt;
    forever begin
      @(note_ev);
      while (note_q.size() > 0) begin
        nt = note_q.pop_front();
        check(32'(obs & nt[23:12]), 32'(nt[11:0]));
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT) begin
      err_count++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // scenarios: autoretry with protection, then latched monitoring; 16-tick startup
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    {sup1, sup2, on1, on2, tfloat, cfg_mon, ovl, shrt, wout} = '0;
    cfg_retry = 1'b1;
    tset = 20'h10;
    void'($urandom(32'hE98D5BA8));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    #1;
    note(ALL, 0, 0, D_OFF, D_OFF);
    $display("reset test done");
    @(posedge clk);
    {sup1, sup2, on1, on2} <= 4'hF;
    wait_bit(10, 1'b1, 3760 * TICK, n);
    check(32'(n >= 3748 * TICK && n <= 3753 * TICK), 32'h1);
    note(ALL, 0, 1, D_START, D_START);
    @(posedge clk);
    shrt <= 2'h1;
    ovl <= 2'h2;
    repeat (30) @(posedge clk);
    #1;
    note(ALL, 0, 1, D_START, D_START);
    @(posedge clk);
    {shrt, ovl} <= 4'h0;
    wait_bit(10, 1'b0, 20 * TICK, n);
    note(ALL, 0, 0, D_LOW, D_LOW);
    wait_bit(0, 1'b0, 80 * TICK, n);
    check(32'(n >= 74 * TICK && n <= 76 * TICK), 32'h1);
    note(ALL, 0, 0, D_GOOD, D_GOOD);
    $display("startup test done");
    @(posedge clk);
    wout <= 2'h3;
    repeat (1 + $urandom % 8) @(posedge clk);
    wout <= 2'h0;
    repeat (10) @(posedge clk);
    #1;
    note(ALL, 0, 0, D_GOOD, D_GOOD);
    @(posedge clk);
    ovl <= 2'h1;
    wait_bit(9, 1'b0, 20, n);
    check(32'(n <= 8), 32'h1);
    repeat (2) @(posedge clk);
    #1;
    note(ALL, 1, 0, D_OFF, D_OFF);
    @(posedge clk);
    ovl <= 2'h0;
    on1 <= 1'b0;
    repeat (20 * TICK) @(posedge clk);
    on1 <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    note(ALL, 1, 0, D_OFF, D_OFF);
    wait_bit(10, 1'b1, 1010 * TICK, n);
    check(32'(n >= 1001 * TICK && n <= 1004 * TICK), 32'h1);
    note(NOF, 0, 1, D_START, D_START);
    $display("slow trip test done");
    wait_bit(10, 1'b0, 20 * TICK, n);
    @(posedge clk);
    shrt <= 2'h2;
    wait_bit(4, 1'b0, 20, n);
    check(32'(n <= 8), 32'h1);
    repeat (2) @(posedge clk);
    #1;
    note(ALL, 1, 0, D_OFF, D_OFF);
    @(posedge clk);
    shrt <= 2'h0;
    sup2 <= 1'b0;
    repeat (12 * TICK) @(posedge clk);
    sup2 <= 1'b1;
    wait_bit(10, 1'b1, 2 * TICK, n);
    note(NOF, 0, 1, D_START, D_START);
    $display("fast trip test done");
    wait_bit(0, 1'b0, 100 * TICK, n);
    @(posedge clk);
    wout <= 2'h2;
    wait_bit(9, 1'b0, 8 * TICK, n);
    check(32'(n >= 2 * TICK), 32'h1);
    repeat (2) @(posedge clk);
    #1;
    note(ALL, 1, 0, D_OFF, D_OFF);
    wait_bit(10, 1'b1, 1030 * TICK, n);
    wait_bit(10, 1'b0, 20 * TICK, n);
    wait_bit(9, 1'b0, 8 * TICK, n);
    repeat (2) @(posedge clk);
    #1;
    note(ALL, 1, 0, D_OFF, D_OFF);
    @(posedge clk);
    wout <= 2'h0;
    wait_bit(10, 1'b1, 1030 * TICK, n);
    wait_bit(0, 1'b0, 100 * TICK, n);
    note(ALL, 0, 0, D_GOOD, D_GOOD);
    $display("window test done");
    @(posedge clk);
    on2 <= 1'b0;
    wait_bit(0, 1'b1, 20, n);
    note(12'h001, 0, 0, 5'h00, 5'h01);
    $display("on-request test done");
    @(posedge clk);
    nrst <= 1'b0;
    cfg_retry <= 1'b0;
    cfg_mon <= 1'b1;
    on2 <= 1'b1;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    note(ALL, 0, 0, D_OFF, D_OFF);
    wait_bit(10, 1'b1, 3760 * TICK, n);
    wait_bit(10, 1'b0, 20 * TICK, n);
    wait_bit(0, 1'b0, 80 * TICK, n);
    @(posedge clk);
    wout <= 2'h2;
    wait_bit(0, 1'b1, 8 * TICK, n);
    repeat (2) @(posedge clk);
    #1;
    note(ALL, 1, 0, D_GOOD, D_LOW);
    @(posedge clk);
    wout <= 2'h0;
    repeat (5) @(posedge clk);
    #1;
    note(ALL, 0, 0, D_GOOD, D_GOOD);
    @(posedge clk);
    ovl <= 2'h2;
    wait_bit(9, 1'b0, 20, n);
    repeat (2) @(posedge clk);
    #1;
    note(ALL, 1, 0, D_OFF, D_OFF);
    @(posedge clk);
    ovl <= 2'h0;
    on1 <= 1'b0;
    repeat (12 * TICK) @(posedge clk);
    #1;
    note(ALL, 1, 0, D_OFF, D_OFF);
    @(posedge clk);
    on1 <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    note(ALL, 0, 0, D_OFF, D_OFF);
    wait_bit(10, 1'b1, 3760 * TICK, n);
    check(32'(n >= 3748 * TICK && n <= 3753 * TICK), 32'h1);
    $display("latched monitor test done");
    end_sim();
  end
endmodule
